// ===== src/cfd_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: one state of the core equals one clk cycle
// Notes:   included by bare name from every design file but the package
`ifndef CFD_DEFINES_SVH
`define CFD_DEFINES_SVH

// flag bit positions in the condition_code_register
`define CFD_FLG_I        3'h7
`define CFD_FLG_H        3'h5
`define CFD_FLG_N        3'h3
`define CFD_FLG_Z        3'h2
`define CFD_FLG_V        3'h1
`define CFD_FLG_C        3'h0
`define CFD_FLG_RST      8'h80

// half-carry watch bit of a word result
`define CFD_HC_BIT       11

// first-byte codes
`define CFD_OP_NOOP      8'h00
`define CFD_OP_SLEEP     8'h01
`define CFD_OP_STF       8'h02
`define CFD_OP_LDF_REG   8'h03
`define CFD_OP_ORF       8'h04
`define CFD_OP_XORF      8'h05
`define CFD_OP_ANDF      8'h06
`define CFD_OP_LDF_IMM   8'h07
`define CFD_OP_ADC_REG   8'h0e
`define CFD_OP_DADJA     8'h0f
`define CFD_OP_NOT_NEG   8'h17
`define CFD_OP_SBB_REG   8'h1e
`define CFD_OP_DADJS     8'h1f
`define CFD_OP_UDIV      8'h51
`define CFD_OP_RTS       8'h54
`define CFD_OP_XRET      8'h56
`define CFD_OP_CALL_RN   8'h5d
`define CFD_OP_CALL_ABS  8'h5e
`define CFD_OP_CALL_IND  8'h5f
`define CFD_OP_MOV_IND   8'h6d
`define CFD_OP_BXOR      8'h75
`define CFD_OP_BLD       8'h77
`define CFD_OP_BLOCK     8'h7b
`define CFD_HI_ADC_IMM   4'h9
`define CFD_HI_SBB_IMM   4'hb
`define CFD_SP_REG       3'h7

// states per cycle type with on-chip memory
`define CFD_S_FETCH      4'h2
`define CFD_S_BRADDR     4'h2
`define CFD_S_STACK      4'h2
`define CFD_S_BYTE       4'h2
`define CFD_S_BYTE_PERI  4'h3
`define CFD_S_WORD       4'h2
`define CFD_S_INTERNAL   4'h1

// block transfer count: 4n + 9
`define CFD_BLK_MUL      12'h004
`define CFD_BLK_ADD      12'h009
`define CFD_CNT_W        12

`endif

// ===== src/cfd_pkg.sv
// Purpose: types shared by the decoder files
// Assumes: constants live in cfd_defines.svh
// Notes:   nothing here is imported; use cfd_pkg::name
package cfd_pkg;

    typedef enum logic [4:0] {
        CFD_NOOP, CFD_SLEEP, CFD_STF, CFD_LDF_REG, CFD_LDF_IMM, CFD_ANDF, CFD_ORF,
        CFD_XORF, CFD_ADC, CFD_SBB, CFD_DADJA, CFD_DADJS, CFD_UDIV, CFD_RTS, CFD_XRET,
        CFD_CALL_RN, CFD_CALL_ABS, CFD_CALL_IND, CFD_MOV_IND, CFD_BLOCK, CFD_ALT_A,
        CFD_ALT_B, CFD_OTHER, CFD_UNDEF
    } cfd_op_e;

    // cycles of each type inside one instruction
    typedef struct packed {
        logic [2:0] fetch;
        logic [2:0] braddr;
        logic [2:0] stack;
        logic [2:0] byte_acc;
        logic [2:0] word_acc;
        logic [2:0] internal;
    } cfd_cyc_s;

    // result facts from the arithmetic unit
    typedef struct packed {
        logic       hc_apply;
        logic       carry11;
        logic       res_zero;
        logic       res_neg;
        logic       ovf;
        logic       carry;
        logic       dec_carry;
        logic [7:0] divisor;
    } cfd_alu_s;

    // decoded instruction
    typedef struct packed {
        cfd_op_e    op;
        logic       stack_mov;
        logic       undef;
    } cfd_dec_s;

endpackage : cfd_pkg

// ===== src/cfd_opmap.sv
// Purpose: first-byte opcode map lookup
// Assumes: instruction word presented whole
// Notes:   purely combinational
`timescale 1ns/1ps
`include "cfd_defines.svh"
module cfd_opmap (
    input  wire logic [15:0]     instr_word, // first instruction word
    output cfd_pkg::cfd_dec_s    dec         // decoded operation
);
    logic [7:0] first_byte;
    assign first_byte = instr_word[15:8];

    // row = high nibble, column = low nibble
    always_comb begin
        dec.stack_mov = 1'b0;
        dec.undef     = 1'b0;
        unique case (first_byte)
            `CFD_OP_NOOP:     dec.op = cfd_pkg::CFD_NOOP;
            `CFD_OP_SLEEP:    dec.op = cfd_pkg::CFD_SLEEP;
            `CFD_OP_STF:      dec.op = cfd_pkg::CFD_STF;
            `CFD_OP_LDF_REG:  dec.op = cfd_pkg::CFD_LDF_REG;
            `CFD_OP_LDF_IMM:  dec.op = cfd_pkg::CFD_LDF_IMM;
            `CFD_OP_ANDF:     dec.op = cfd_pkg::CFD_ANDF;
            `CFD_OP_ORF:      dec.op = cfd_pkg::CFD_ORF;
            `CFD_OP_XORF:     dec.op = cfd_pkg::CFD_XORF;
            `CFD_OP_ADC_REG:  dec.op = cfd_pkg::CFD_ADC;
            `CFD_OP_SBB_REG:  dec.op = cfd_pkg::CFD_SBB;
            `CFD_OP_DADJA:    dec.op = cfd_pkg::CFD_DADJA;
            `CFD_OP_DADJS:    dec.op = cfd_pkg::CFD_DADJS;
            `CFD_OP_UDIV:     dec.op = cfd_pkg::CFD_UDIV;
            `CFD_OP_RTS:      dec.op = cfd_pkg::CFD_RTS;
            `CFD_OP_XRET:     dec.op = cfd_pkg::CFD_XRET;
            `CFD_OP_CALL_RN:  dec.op = cfd_pkg::CFD_CALL_RN;
            `CFD_OP_CALL_ABS: dec.op = cfd_pkg::CFD_CALL_ABS;
            `CFD_OP_CALL_IND: dec.op = cfd_pkg::CFD_CALL_IND;
            `CFD_OP_BLOCK:    dec.op = cfd_pkg::CFD_BLOCK;
            // push and pop are this move with the stack pointer
            `CFD_OP_MOV_IND: begin
                dec.op        = cfd_pkg::CFD_MOV_IND;
                dec.stack_mov = (instr_word[6:4] == `CFD_SP_REG);
            end
            // shared codes split on bit 7 of the word
            `CFD_OP_NOT_NEG, `CFD_OP_BXOR, `CFD_OP_BLD: begin
                dec.op = instr_word[7] ? cfd_pkg::CFD_ALT_B : cfd_pkg::CFD_ALT_A;
            end
            8'h52, 8'h53, 8'h57, 8'h58, 8'h5c, 8'h64, 8'h65, 8'h66, 8'h78: begin
                dec.op    = cfd_pkg::CFD_UNDEF;
                dec.undef = 1'b1;
            end
            default: begin
                if (first_byte[7:4] == `CFD_HI_ADC_IMM) begin
                    dec.op = cfd_pkg::CFD_ADC;
                end else if (first_byte[7:4] == `CFD_HI_SBB_IMM) begin
                    dec.op = cfd_pkg::CFD_SBB;
                end else begin
                    dec.op = cfd_pkg::CFD_OTHER;
                end
            end
        endcase
    end
endmodule // cfd_opmap

// ===== src/cfd_states.sv
// Purpose: execution state total from cycle counts
// Assumes: per-cycle state counts for on-chip memory
// Notes:   byte access to a peripheral costs one state more
`timescale 1ns/1ps
`include "cfd_defines.svh"
module cfd_states (
    input  cfd_pkg::cfd_cyc_s    cyc,        // cycles of each type
    input  wire logic            peri_byte,  // byte data goes to a peripheral
    output logic [11:0]          total       // execution states
);
    function automatic logic [11:0] term(input logic [2:0] n, input logic [3:0] s);
        term = 12'(n) * 12'(s);
    endfunction

    // sum of count times states per type
    always_comb begin
        total = term(cyc.fetch, `CFD_S_FETCH)
              + term(cyc.braddr, `CFD_S_BRADDR)
              + term(cyc.stack, `CFD_S_STACK)
              + term(cyc.byte_acc, peri_byte ? `CFD_S_BYTE_PERI : `CFD_S_BYTE)
              + term(cyc.word_acc, `CFD_S_WORD)
              + term(cyc.internal, `CFD_S_INTERNAL);
    end
endmodule // cfd_states

// ===== src/cfd_decoder.sv
// Purpose: control-flow, flag-transfer and flag-rule decode of the cpu core
// Assumes: one state per clk; an instruction is taken when ready_o and instr_valid
// Notes:   undefined first bytes run as a two-state no-op and pulse undef_o
// How it works
// - half-carry from bit 11 carry or borrow
// - extended add/sub zero keeps zero flag
// - decimal adjust sets carry or keeps it
// - block transfer takes 4n+9 states
// - divide negative flag tracks divisor sign
// - divide zero flag tracks zero divisor
// - first byte selects row and column
// - bit 7 splits shared first bytes
// - push/pop are stack-pointer indirect moves
// - state counts assume on-chip memory
// - sleep entry keeps flags, two states
// - states are sum of cycles times states
`timescale 1ns/1ps
`include "cfd_defines.svh"
module cfd_decoder (
    input  wire logic            clk,          // core clock, 20 MHz
    input  wire logic            sys_rst,      // synchronous reset, high
    input  wire logic            instr_valid,  // instruction word offered
    input  wire logic [15:0]     instr_word,   // first instruction word
    input  wire logic [7:0]      imm_or_reg,   // immediate byte or source register
    input  wire logic [7:0]      stack_flags,  // flag byte popped on exception return
    input  wire logic [7:0]      reg4_low,     // general_reg4_low_byte value
    input  wire logic            peri_byte,    // byte data goes to a peripheral
    input  cfd_pkg::cfd_alu_s    alu,          // arithmetic result facts
    input  wire logic            wake,         // leave sleep mode
    output logic                 ready_o,      // idle, can take an instruction
    output logic                 done_o,       // last state of the instruction
    output cfd_pkg::cfd_dec_s    dec_o,        // decoded instruction, registered
    output logic [11:0]          states_o,     // state count, registered
    output logic [7:0]           cc_reg_o,     // condition_code_register
    output logic [7:0]           store_o,      // store_flags data, registered
    output logic                 sleep_o,      // sleep mode
    output logic                 undef_o       // undefined code taken, pulse
);
    typedef enum logic [1:0] {
        CFD_IDLE = 2'b01,
        CFD_EXEC = 2'b10
    } cfd_state_e;

    cfd_state_e          state_r;
    cfd_pkg::cfd_dec_s   dec;
    cfd_pkg::cfd_cyc_s   cyc;
    logic [11:0]         table_total;
    logic [11:0]         total_nxt;
    logic [11:0]         cnt_r;
    logic [7:0]          cc_reg_r;
    logic [7:0]          cc_reg_nxt;
    logic [7:0]          reg4_low_q;
    logic                take;
    logic                undef_r;

    cfd_opmap u_opmap (
        .instr_word (instr_word),
        .dec        (dec)
    );

    cfd_states u_states (
        .cyc        (cyc),
        .peri_byte  (peri_byte),
        .total      (table_total)
    );

    // 4n + 9 for the block transfer
    function automatic logic [11:0] block_states(input logic [7:0] n);
        block_states = 12'(n) * `CFD_BLK_MUL + `CFD_BLK_ADD;
    endfunction

    assign take    = (state_r == CFD_IDLE) && instr_valid;
    assign ready_o = (state_r == CFD_IDLE);
    assign done_o  = (state_r == CFD_EXEC) && (cnt_r == 12'h001);

    // cycle mix of each instruction
    always_comb begin
        cyc = '0;
        unique case (dec.op)
            cfd_pkg::CFD_CALL_RN: begin
                cyc.fetch = 3'h2;
                cyc.stack = 3'h1;
            end
            cfd_pkg::CFD_CALL_ABS, cfd_pkg::CFD_RTS: begin
                cyc.fetch    = 3'h2;
                cyc.stack    = 3'h1;
                cyc.internal = 3'h2;
            end
            cfd_pkg::CFD_CALL_IND: begin
                cyc.fetch  = 3'h2;
                cyc.braddr = 3'h1;
                cyc.stack  = 3'h1;
            end
            cfd_pkg::CFD_XRET: begin
                cyc.fetch    = 3'h2;
                cyc.stack    = 3'h2;
                cyc.internal = 3'h2;
            end
            cfd_pkg::CFD_MOV_IND: begin
                cyc.fetch    = 3'h1;
                cyc.word_acc = 3'h1;
                cyc.internal = {2'h0, dec.stack_mov};
            end
            cfd_pkg::CFD_ALT_A, cfd_pkg::CFD_ALT_B: begin
                cyc.fetch    = 3'h1;
            end
            default: begin
                cyc.fetch = 3'h1; // sleep, flag ops, no-op, undefined
            end
        endcase
    end

    // block transfer overrides the table sum
    always_comb begin
        if (dec.op == cfd_pkg::CFD_BLOCK) begin
            total_nxt = block_states(reg4_low);
        end else begin
            total_nxt = table_total;
        end
    end

    // flag update of the taken instruction
    always_comb begin
        cc_reg_nxt = cc_reg_r;
        unique case (dec.op)
            cfd_pkg::CFD_LDF_REG, cfd_pkg::CFD_LDF_IMM: cc_reg_nxt = imm_or_reg;
            cfd_pkg::CFD_ANDF: cc_reg_nxt = cc_reg_r & imm_or_reg;
            cfd_pkg::CFD_ORF:  cc_reg_nxt = cc_reg_r | imm_or_reg;
            cfd_pkg::CFD_XORF: cc_reg_nxt = cc_reg_r ^ imm_or_reg;
            cfd_pkg::CFD_XRET: cc_reg_nxt = stack_flags;
            cfd_pkg::CFD_ADC, cfd_pkg::CFD_SBB: begin
                cc_reg_nxt[`CFD_FLG_H] = alu.carry11;
                cc_reg_nxt[`CFD_FLG_N] = alu.res_neg;
                cc_reg_nxt[`CFD_FLG_V] = alu.ovf;
                cc_reg_nxt[`CFD_FLG_C] = alu.carry;
                if (!alu.res_zero) begin
                    cc_reg_nxt[`CFD_FLG_Z] = 1'b0;
                end
            end
            cfd_pkg::CFD_DADJA, cfd_pkg::CFD_DADJS: begin
                cc_reg_nxt[`CFD_FLG_N] = alu.res_neg;
                cc_reg_nxt[`CFD_FLG_Z] = alu.res_zero;
                if (alu.dec_carry) begin
                    cc_reg_nxt[`CFD_FLG_C] = 1'b1;
                end
            end
            cfd_pkg::CFD_UDIV: begin
                cc_reg_nxt[`CFD_FLG_N] = alu.divisor[7];
                cc_reg_nxt[`CFD_FLG_Z] = (alu.divisor == 8'h00);
            end
            cfd_pkg::CFD_OTHER: begin
                if (alu.hc_apply) begin
                    cc_reg_nxt[`CFD_FLG_H] = alu.carry11;
                end
            end
            default: cc_reg_nxt = cc_reg_r; // sleep, no-op, undefined keep flags
        endcase
    end

    // idle/exec sequencing and state countdown
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= CFD_IDLE;
            cnt_r   <= 12'h000;
        end else if (take) begin
            state_r <= CFD_EXEC;
            cnt_r   <= total_nxt;
        end else if (state_r == CFD_EXEC) begin
            cnt_r <= cnt_r - 12'h001;
            if (cnt_r == 12'h001) begin
                state_r <= CFD_IDLE;
            end
        end
    end

    // decoded fields held for the whole execution
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dec_o    <= '{op: cfd_pkg::CFD_NOOP, stack_mov: 1'b0, undef: 1'b0};
            states_o <= 12'h000;
            store_o  <= 8'h00;
            undef_r  <= 1'b0;
        end else begin
            undef_r <= take && dec.undef;
            if (take) begin
                dec_o    <= dec;
                states_o <= total_nxt;
                store_o  <= cc_reg_r;
            end
        end
    end

    // flags live here; only taken instructions change them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cc_reg_r <= `CFD_FLG_RST;
        end else if (take) begin
            cc_reg_r <= cc_reg_nxt;
        end
    end

    // sleep entered by the instruction, left on wake
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sleep_o <= 1'b0;
        end else if (take && dec.op == cfd_pkg::CFD_SLEEP) begin
            sleep_o <= 1'b1;
        end else if (wake) begin
            sleep_o <= 1'b0;
        end
    end

    assign cc_reg_o = cc_reg_r;
    assign undef_o = undef_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_take_sleep;
        take && dec.op == cfd_pkg::CFD_SLEEP;
    endsequence

    sequence s_two_states;
        !done_o ##1 done_o;
    endsequence

    a_sleep_two_states: assert property (
        s_take_sleep |=> s_two_states ##0 $stable(cc_reg_o) ##0 sleep_o)
        else $error("sleep entry not two states or flags moved");

    a_block_count: assert property (
        take && dec.op == cfd_pkg::CFD_BLOCK |=>
            states_o == 12'(reg4_low_q) * 12'h004 + 12'h009)
        else $error("block transfer state count wrong");

    // n at the taking edge, seen by the check one cycle later
    always_ff @(posedge clk) begin
        reg4_low_q <= reg4_low;
    end

    a_extsub_zero: assert property (
        take && (dec.op == cfd_pkg::CFD_ADC || dec.op == cfd_pkg::CFD_SBB) |=>
            cc_reg_o[2] == ($past(alu.res_zero) ? $past(cc_reg_o[2]) : 1'b0))
        else $error("extended arithmetic zero flag wrong");

    a_half_carry: assert property (
        take && dec.op == cfd_pkg::CFD_ADC |=> cc_reg_o[5] == $past(alu.carry11))
        else $error("half carry not from bit 11");

    a_decadj_carry: assert property (
        take && dec.op == cfd_pkg::CFD_DADJA |=>
            cc_reg_o[0] == ($past(alu.dec_carry) | $past(cc_reg_o[0])))
        else $error("decimal adjust carry wrong");

    a_div_flags: assert property (
        take && dec.op == cfd_pkg::CFD_UDIV |=>
            cc_reg_o[3] == $past(alu.divisor[7]) &&
            cc_reg_o[2] == ($past(alu.divisor) == 8'h00))
        else $error("divide flags wrong");

    a_split_bit7: assert property (
        instr_word[15:8] == 8'h17 |-> (dec.op == cfd_pkg::CFD_ALT_B) == instr_word[7])
        else $error("shared code split wrong");

    a_jsr_rn_states: assert property (
        take && dec.op == cfd_pkg::CFD_CALL_RN |=> states_o == 12'h006 ##5 done_o)
        else $error("call through register not six states");

    a_push_pop: assert property (
        instr_word[15:8] == 8'h6d && instr_word[6:4] == 3'h7 |-> dec.stack_mov)
        else $error("stack move not recognised");

    a_undef_pulse: assert property (
        take && dec.undef |=> undef_o && states_o == 12'h002 && $stable(cc_reg_o))
        else $error("undefined code handling wrong");

endmodule // cfd_decoder

// ===== bench/cpu_control_flow_and_opcode_decode_tb.sv
// Purpose: self-checking bench for the control-flow and flag decoder
// Assumes: inputs move 1 ns after the rising edge; one state per clk
// Notes:   each scenario is a task that drives the decoder and judges it
`timescale 1ns/1ps
`include "cfd_defines.svh"
module cpu_control_flow_and_opcode_decode_tb;
    logic               clk;
    logic               sys_rst;
    logic               instr_valid;
    logic [15:0]        instr_word;
    logic [7:0]         imm_or_reg;
    logic [7:0]         stack_flags;
    logic [7:0]         reg4_low;
    logic               peri_byte;
    cfd_pkg::cfd_alu_s  alu;
    logic               wake;
    logic               ready_o;
    logic               done_o;
    cfd_pkg::cfd_dec_s  dec_o;
    logic [11:0]        states_o;
    logic [7:0]         cc_reg_o;
    logic [7:0]         store_o;
    logic               sleep_o;
    logic               undef_o;
    logic               undef_seen;  // undef_o in the first exec cycle
    int                 errors;
    int                 n_checks;

    // 20 MHz core clock
    always #25 clk = ~clk;

    cfd_decoder u_dut (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .instr_valid (instr_valid),
        .instr_word  (instr_word),
        .imm_or_reg  (imm_or_reg),
        .stack_flags (stack_flags),
        .reg4_low    (reg4_low),
        .peri_byte   (peri_byte),
        .alu         (alu),
        .wake        (wake),
        .ready_o     (ready_o),
        .done_o      (done_o),
        .dec_o       (dec_o),
        .states_o    (states_o),
        .cc_reg_o    (cc_reg_o),
        .store_o     (store_o),
        .sleep_o     (sleep_o),
        .undef_o     (undef_o)
    );

    // single compare; the 16-bit width covers flags, counts and codes
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one instruction: offer, hold to the taking edge, count states to done
    task automatic issue(input logic [15:0] w, input logic [7:0] v);
        int n;
        n = 1;
        cmp(ready_o, 1'b1);
        instr_word  = w;
        imm_or_reg  = v;
        instr_valid = 1'b1;
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
        undef_seen  = undef_o;
        while (done_o !== 1'b1 && n < 1100) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp(states_o, n[11:0]);
        @(posedge clk);
        #1;
    endtask

    task automatic set_flags(input logic [7:0] v);
        issue({`CFD_OP_LDF_IMM, 8'h00}, v);
    endtask

    task automatic t_reset();
        cmp(cc_reg_o, `CFD_FLG_RST);
        cmp(done_o, 1'b0);
        cmp(sleep_o, 1'b0);
        cmp(undef_o, 1'b0);
        cmp(states_o, 12'h000);
        cmp(store_o, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_flags();
        stack_flags = 8'h05;
        set_flags(8'h2b);
        cmp(cc_reg_o, 8'h2b);
        cmp(states_o, 12'h002);
        issue({`CFD_OP_ORF, 8'h00}, 8'h40);
        cmp(cc_reg_o, 8'h6b);
        issue({`CFD_OP_XORF, 8'h00}, 8'h0f);
        cmp(cc_reg_o, 8'h64);
        issue({`CFD_OP_ANDF, 8'h00}, 8'hf0);
        cmp(cc_reg_o, 8'h60);
        issue({`CFD_OP_STF, 8'h00}, 8'hff);
        cmp(store_o, 8'h60);
        cmp(cc_reg_o, 8'h60);
        issue({`CFD_OP_LDF_REG, 8'h00}, 8'h81);
        cmp(cc_reg_o, 8'h81);
        issue({`CFD_OP_XRET, 8'h00}, 8'h00);
        cmp(cc_reg_o, 8'h05);
        $display("test flags done");
    endtask

    task automatic t_sleep();
        set_flags(8'h0a);
        issue({`CFD_OP_SLEEP, 8'h00}, 8'hff);
        cmp(states_o, 12'h002);
        cmp(cc_reg_o, 8'h0a);
        cmp(sleep_o, 1'b1);
        wake = 1'b1;
        @(posedge clk);
        #1;
        wake = 1'b0;
        @(posedge clk);
        #1;
        cmp(sleep_o, 1'b0);
        issue({`CFD_OP_NOOP, 8'h00}, 8'hff);
        cmp(states_o, 12'h002);
        cmp(cc_reg_o, 8'h0a);
        $display("test sleep done");
    endtask

    // count boundaries: n of zero, mid and full byte
    task automatic t_block();
        logic [7:0] nv [3] = '{8'h00, 8'h05, 8'hff};
        for (int i = 0; i < 3; i++) begin
            reg4_low = nv[i];
            issue({`CFD_OP_BLOCK, 8'h00}, 8'h00);
            cmp(states_o, 12'(4 * nv[i] + 9));
            cmp(dec_o.op, cfd_pkg::CFD_BLOCK);
        end
        $display("test block done");
    endtask

    // peripheral byte flag must not touch instructions without byte access
    task automatic t_calls();
        logic [7:0]       code [5] = '{8'h5d, 8'h5e, 8'h5f, 8'h54, 8'h56};
        logic [11:0]      st [5] = '{12'h006, 12'h008, 12'h008, 12'h008, 12'h00a};
        cfd_pkg::cfd_op_e op [5] = '{cfd_pkg::CFD_CALL_RN, cfd_pkg::CFD_CALL_ABS,
            cfd_pkg::CFD_CALL_IND, cfd_pkg::CFD_RTS, cfd_pkg::CFD_XRET};
        stack_flags = 8'h8f;
        peri_byte   = 1'b1;
        for (int i = 0; i < 5; i++) begin
            issue({code[i], 8'h00}, 8'h00);
            cmp(states_o, st[i]);
            cmp(dec_o.op, op[i]);
        end
        cmp(cc_reg_o, 8'h8f);
        peri_byte = 1'b0;
        $display("test calls done");
    endtask

    task automatic t_div();
        logic [7:0] dv [3] = '{8'h80, 8'h00, 8'h05};
        logic       en [3] = '{1'b1, 1'b0, 1'b0};
        logic       ez [3] = '{1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 3; i++) begin
            set_flags(8'h0c);
            alu.divisor = dv[i];
            issue({`CFD_OP_UDIV, 8'h00}, 8'h00);
            cmp(cc_reg_o[`CFD_FLG_N], en[i]);
            cmp(cc_reg_o[`CFD_FLG_Z], ez[i]);
        end
        $display("test divide done");
    endtask

    // register and immediate forms of extended add and subtract
    task automatic t_add_with_carry();
        logic [15:0] w [4] = '{16'h0e12, 16'h1e12, 16'h9312, 16'hb312};
        for (int i = 0; i < 4; i++) begin
            set_flags(8'h04);
            alu.res_zero = 1'b1;
            alu.carry11  = 1'b1;
            issue(w[i], 8'h00);
            cmp(cc_reg_o[`CFD_FLG_Z], 1'b1);
            cmp(cc_reg_o[`CFD_FLG_H], 1'b1);
            alu.res_zero = 1'b0;
            alu.carry11  = 1'b0;
            issue(w[i], 8'h00);
            cmp(cc_reg_o[`CFD_FLG_Z], 1'b0);
            cmp(cc_reg_o[`CFD_FLG_H], 1'b0);
            set_flags(8'h00);
            alu.res_zero = 1'b1;
            issue(w[i], 8'h00);
            cmp(cc_reg_o[`CFD_FLG_Z], 1'b0);
        end
        alu = '0;
        $display("test extended done");
    endtask

    task automatic t_daa();
        logic [15:0] w [2] = '{16'h0f00, 16'h1f00};
        for (int i = 0; i < 2; i++) begin
            set_flags(8'h01);
            alu.carry     = 1'b1;
            alu.dec_carry = 1'b0;
            issue(w[i], 8'h00);
            cmp(cc_reg_o[`CFD_FLG_C], 1'b1);
            set_flags(8'h00);
            alu.carry = 1'b0;
            issue(w[i], 8'h00);
            cmp(cc_reg_o[`CFD_FLG_C], 1'b0);
            alu.dec_carry = 1'b1;
            issue(w[i], 8'h00);
            cmp(cc_reg_o[`CFD_FLG_C], 1'b1);
        end
        alu = '0;
        $display("test decimal done");
    endtask

    task automatic t_undef();
        logic [7:0] code [9] = '{8'h52, 8'h53, 8'h57, 8'h58, 8'h5c,
            8'h64, 8'h65, 8'h66, 8'h78};
        set_flags(8'h8a);
        for (int i = 0; i < 9; i++) begin
            issue({code[i], 8'h00}, 8'h00);
            cmp(undef_seen, 1'b1);
            cmp(undef_o, 1'b0);
            cmp(dec_o.undef, 1'b1);
            cmp(states_o, 12'h002);
            cmp(cc_reg_o, 8'h8a);
        end
        issue({`CFD_OP_NOOP, 8'h00}, 8'h00);
        cmp(undef_seen, 1'b0);
        $display("test undefined done");
    endtask

    // shared first bytes, split on the top bit of the second byte
    task automatic t_split();
        logic [7:0] code [3] = '{8'h17, 8'h75, 8'h77};
        for (int i = 0; i < 3; i++) begin
            issue({code[i], 8'h00}, 8'h00);
            cmp(dec_o.op, cfd_pkg::CFD_ALT_A);
            issue({code[i], 8'h80}, 8'h00);
            cmp(dec_o.op, cfd_pkg::CFD_ALT_B);
        end
        $display("test split done");
    endtask

    task automatic t_stack();
        issue(16'h6d70, 8'h00);
        cmp(dec_o.stack_mov, 1'b1);
        cmp(states_o, 12'h005);
        issue(16'h6df3, 8'h00);
        cmp(dec_o.stack_mov, 1'b1);
        issue(16'h6d20, 8'h00);
        cmp(dec_o.stack_mov, 1'b0);
        cmp(dec_o.op, cfd_pkg::CFD_MOV_IND);
        cmp(states_o, 12'h004);
        $display("test stack done");
    endtask

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // main sequence: 8-cycle reset, then scenarios
    initial begin
        clk         = 1'b0;
        sys_rst     = 1'b1;
        instr_valid = 1'b0;
        instr_word  = 16'h0000;
        imm_or_reg  = 8'h00;
        stack_flags = 8'h00;
        reg4_low    = 8'h00;
        peri_byte   = 1'b0;
        alu         = '0;
        wake        = 1'b0;
        undef_seen  = 1'b0;
        errors      = 0;
        n_checks    = 0;
        repeat (8) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_flags();
        t_sleep();
        t_block();
        t_calls();
        t_div();
        t_add_with_carry();
        t_daa();
        t_undef();
        t_split();
        t_stack();
        report_and_stop();
    end

    // watchdog: run needs about 1300 cycles, allow 20000
    initial begin
        #1000000;
        errors++;
        report_and_stop();
    end
endmodule // cpu_control_flow_and_opcode_decode_tb
